// ### inc/afs_defs.svh
// Purpose: constants for the adaptive fullstep step handshake block
// Assumes: 100 MHz i_mclk, APB with 32-bit data
// Notes:   offsets are byte addresses
//
// What this block does
// - diag out zero pulls low throughout reset, whatever is selected.
// - each diag out is open drain low or push-pull high, signal selectable.
// - stall is active when load result is zero and interval within cool threshold.
// - index is active while the microstep position is zero.
// - index lasts exactly as long as the current microstep, down to two clocks.
// - chopper on-state shows both coil choppers' on-phases alternately.
// - skipped-step diag toggles once per step the sequencer does not take.
// - adaptive mode forces constant off-time chopping via o_chop_const_off.
// - enable input high forces adaptive fullstep operation.
// - adaptive operation is inhibited while the quiet voltage chopper is active.
// - step ready is low when the motor cannot take a step, else high.
// - while not ready, buffer steps up to the microsteps per fullstep.
// - step held high over 1024 clocks, or minimum velocity, forces a step.
// - sync input low halts step execution and forces step ready low.
// - lost-step counter counts untaken steps by direction; readable.
// - adaptive mode commutates in fullsteps whatever resolution is set.
// - a blocked motor is still stepped at the minimum adaptive velocity.
// - a completely blocked motor sets the stall flag.
// - direction low moves the position up, high moves it down.
// - a minimum adaptive velocity of zero disables the enforcement.
`ifndef AFS_DEFS_SVH
`define AFS_DEFS_SVH
// ==========================================
// register map
`define AFS_OFS_CTRL   12'h000
`define AFS_OFS_MINVEL 12'h004
`define AFS_OFS_COOL   12'h008
`define AFS_OFS_QUIET  12'h00C
`define AFS_OFS_MRES   12'h010
`define AFS_OFS_STAT   12'h014
`define AFS_OFS_LOST   12'h018
`define AFS_OFS_POS    12'h01C
// ==========================================
// control fields and reset values
`define AFS_CTL_EN     0
`define AFS_CTL_S0_LO  1
`define AFS_CTL_PP0    4
`define AFS_CTL_S1_LO  5
`define AFS_CTL_PP1    8
`define AFS_CTRL_RST   32'h0000_0020
`define AFS_MRES_RST   4'h8
`define AFS_MRES_MAX   4'h8
// ==========================================
// timing
`define AFS_CLK_MHZ    100
`define AFS_LONG_CLK   11'h400
`define AFS_IVL_MAX    20'hF_FFFF
`endif

// ### inc/afs_pkg.sv
// Purpose: types for the adaptive fullstep step handshake block
// Assumes: nothing
// Notes:   diag selection codes above the last entry read as inactive
`default_nettype none
package afs_pkg;
    // ==========================================
    // diag signal selection
    typedef enum logic [2:0] {
        AFS_STALL,
        AFS_INDEX,
        AFS_CHOP,
        AFS_SKIP,
        AFS_BLOCK
    } afs_dsel_t;
endpackage : afs_pkg
`default_nettype wire

// ### src/afs_step_ctl.sv
// Purpose: step sequencer, ready handshake, lost-step count and diag outputs
// Assumes: step, dir, sync and enable arrive from the controller pins
// Notes:   APB slave answers with no wait state
`include "afs_defs.svh"
`default_nettype none
module afs_step_ctl #(
    parameter int VW = 23
) (
    // clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_rst,
    // apb slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // controller pins
    input  wire logic        i_step,
    input  wire logic        i_dir,
    input  wire logic        i_step_sync_in,
    input  wire logic        i_adaptive_mode_enable_in,
    output logic             o_step_ready_out,
    // load measurement and chopper
    input  wire logic [9:0]  i_load_measure_result,
    input  wire logic        i_step_taken,
    input  wire logic        i_chop_on_a,
    input  wire logic        i_chop_on_b,
    output logic             o_chop_const_off,
    output logic             o_adaptive_active,
    // diag pins
    output logic             o_diag_out_zero,
    output logic             o_diag_out_zero_oe,
    output logic             o_diag_out_one,
    output logic             o_diag_out_one_oe
);
    // ==========================================
    // input synchronisers
    logic [3:0] sy1_q;
    logic [3:0] sy2_q;
    logic       step_p_q;
    // first stage feeds only the second one
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            sy1_q    <= 4'h0;
            sy2_q    <= 4'h0;
            step_p_q <= 1'b0;
        end
        else
        begin
            sy1_q    <= {i_adaptive_mode_enable_in, i_step_sync_in, i_dir, i_step};
            sy2_q    <= sy1_q;
            step_p_q <= sy2_q[0];
        end
    end
    wire step_s  = sy2_q[0];
    wire dir_s   = sy2_q[1];
    wire sync_s  = sy2_q[2];
    wire en_s    = sy2_q[3];
    wire step_rs = step_s & ~step_p_q;

    // ==========================================
    // registers
    logic [31:0]   ctrl_q;
    logic [VW-1:0] minvel_q;
    logic [19:0]   cool_q;
    logic [19:0]   quiet_q;
    logic [3:0]    mres_q;
    logic          stall_q;
    logic [19:0]   lost_q;
    logic [9:0]    pos_q;
    logic [19:0]   step_interval_measured_q;

    // apb decode: write lands at the access edge
    wire acc    = i_psel & i_penable & o_pready;
    wire wr     = acc & i_pwrite;
    wire setup  = i_psel & ~i_penable & ~o_pready;
    wire hit_c  = i_paddr == `AFS_OFS_CTRL;
    wire hit_m  = i_paddr == `AFS_OFS_MINVEL;
    wire hit_k  = i_paddr == `AFS_OFS_COOL;
    wire hit_q  = i_paddr == `AFS_OFS_QUIET;
    wire hit_r  = i_paddr == `AFS_OFS_MRES;
    wire hit_s  = i_paddr == `AFS_OFS_STAT;
    wire hit_l  = i_paddr == `AFS_OFS_LOST;
    wire hit_p  = i_paddr == `AFS_OFS_POS;
    wire mapped = hit_c | hit_m | hit_k | hit_q | hit_r | hit_s | hit_l | hit_p;

    // ==========================================
    // mode and velocity
    logic [19:0] ivl_q;
    // quiet chopper runs at long intervals, i.e. low velocity
    wire quiet    = (quiet_q != 20'h0_0000) & (step_interval_measured_q >= quiet_q);
    wire adaptive = (en_s | ctrl_q[`AFS_CTL_EN]) & ~quiet;
    wire stall_s  = (i_load_measure_result == 10'h000) & (step_interval_measured_q <= cool_q);

    // ==========================================
    // sequencer arithmetic
    logic signed [10:0] pend_q;
    logic [10:0]        hi_q;
    logic [VW-1:0]      wait_q;
    wire [3:0]  mres_c = (mres_q > `AFS_MRES_MAX) ? `AFS_MRES_MAX : mres_q;
    wire [9:0]  ust_w  = 10'h100 >> mres_c;
    wire [9:0]  fs_cnt = 10'h001 << mres_c;
    wire        neg    = pend_q[10];
    wire [10:0] pend_a = neg ? 11'(-pend_q) : 11'(pend_q);
    // buffer holds one fullstep worth of microsteps
    wire        full   = pend_a >= {1'b0, fs_cnt};
    // long pulse: reached on the 1025th clock high
    wire f_long   = step_s & (hi_q == `AFS_LONG_CLK);
    // zero minimum velocity disables the forced step
    wire f_min    = (minvel_q != '0) & (wait_q >= minvel_q);
    wire exec     = adaptive & sync_s & full & (i_step_taken | f_long | f_min);
    wire untaken  = adaptive & step_rs & full & ~exec;
    wire take_in  = adaptive & step_rs & ~untaken;
    wire blocked  = exec & ~i_step_taken & f_min;
    wire [10:0] inc    = dir_s ? 11'h7FF : 11'h001;
    wire [10:0] fs_s   = neg ? {1'b0, fs_cnt} : 11'(-{1'b0, fs_cnt});
    wire [9:0]  fs_pos = {pos_q[9:8], 8'h80};
    // fullstep snap then move by a quarter table
    wire [9:0]  pos_fs = neg ? 10'(fs_pos - 10'h100) : 10'(fs_pos + 10'h100);
    wire [9:0]  pos_us = dir_s ? 10'(pos_q - ust_w) : 10'(pos_q + ust_w);
    wire        us_go  = ~adaptive & sync_s & step_rs;

    // ==========================================
    // sequencer state
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            pend_q <= 11'sh000;
            pos_q  <= 10'h000;
            lost_q <= 20'h0_0000;
        end
        else
        begin
            if (!adaptive)
                pend_q <= 11'sh000;
            else
                pend_q <= pend_q + (take_in ? inc : 11'h000) + (exec ? fs_s : 11'h000);
            if (exec)
                pos_q <= pos_fs;
            else if (us_go)
                pos_q <= pos_us;
            if (wr && hit_l)
                lost_q <= 20'h0_0000;
            else if (untaken)
                lost_q <= 20'(lost_q + {{9{inc[10]}}, inc});
        end
    end

    // interval, pulse width and wait counters
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            ivl_q   <= 20'h0_0000;
            step_interval_measured_q <= `AFS_IVL_MAX;
            hi_q    <= 11'h000;
            wait_q  <= '0;
        end
        else
        begin
            ivl_q   <= step_rs ? 20'h0_0001 : ((ivl_q == `AFS_IVL_MAX) ? ivl_q : ivl_q + 1'b1);
            step_interval_measured_q <= step_rs ? ivl_q : ((ivl_q > step_interval_measured_q) ? ivl_q : step_interval_measured_q);
            hi_q    <= !step_s ? 11'h000 : (f_long ? hi_q + 1'b1 : (hi_q[10] ? hi_q : hi_q + 1'b1));
            wait_q  <= (exec || !full) ? '0 : ((wait_q == '1) ? wait_q : wait_q + 1'b1);
        end
    end

    // ==========================================
    // diag signal sources
    logic skip_q;
    logic alt_q;
    logic chop_p_q;
    wire  chop_sel = alt_q ? i_chop_on_b : i_chop_on_a;
    // index straight from position, so it lasts one microstep
    wire  index_s  = pos_q == 10'h000;
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            skip_q   <= 1'b0;
            alt_q    <= 1'b0;
            chop_p_q <= 1'b0;
            stall_q  <= 1'b0;
        end
        else
        begin
            skip_q   <= skip_q ^ untaken;
            chop_p_q <= chop_sel;
            alt_q    <= alt_q ^ (chop_p_q & ~chop_sel);
            // set wins over the write-one clear
            stall_q  <= blocked | (stall_q & ~(wr & hit_s & i_pwdata[0]));
        end
    end

    // map a selection code to a level
    function automatic logic pick(input logic [2:0] s, input logic a, input logic b,
                                  input logic c, input logic d, input logic e);
        logic r;
        r = 1'b0;
        unique case (afs_pkg::afs_dsel_t'(s))
            afs_pkg::AFS_STALL: r = a;
            afs_pkg::AFS_INDEX: r = b;
            afs_pkg::AFS_CHOP:  r = c;
            afs_pkg::AFS_SKIP:  r = d;
            afs_pkg::AFS_BLOCK: r = e;
            default:            r = 1'b0;
        endcase
        return r;
    endfunction : pick

    wire act0 = pick(ctrl_q[`AFS_CTL_S0_LO +: 3], stall_s, index_s, chop_sel, skip_q, stall_q);
    wire act1 = pick(ctrl_q[`AFS_CTL_S1_LO +: 3], stall_s, index_s, chop_sel, skip_q, stall_q);
    wire pp0  = ctrl_q[`AFS_CTL_PP0];
    wire pp1  = ctrl_q[`AFS_CTL_PP1];

    // ==========================================
    // pin drivers; open drain pulls low only while active or, for diag zero, throughout reset
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_diag_out_zero    <= 1'b0;
            o_diag_out_zero_oe <= 1'b1;
            o_diag_out_one     <= 1'b0;
            o_diag_out_one_oe  <= 1'b0;
            o_step_ready_out   <= 1'b0;
            o_chop_const_off   <= 1'b0;
            o_adaptive_active  <= 1'b0;
        end
        else
        begin
            o_diag_out_zero    <= pp0 & act0;
            o_diag_out_zero_oe <= pp0 | act0;
            o_diag_out_one     <= pp1 & act1;
            o_diag_out_one_oe  <= pp1 | act1;
            o_step_ready_out   <= sync_s & (~adaptive | i_step_taken);
            o_chop_const_off   <= adaptive;
            o_adaptive_active  <= adaptive;
        end
    end

    // ==========================================
    // apb registers
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            ctrl_q   <= `AFS_CTRL_RST;
            minvel_q <= '0;
            cool_q   <= 20'h0_0000;
            quiet_q  <= 20'h0_0000;
            mres_q   <= `AFS_MRES_RST;
        end
        else if (wr)
        begin
            if (hit_c)
                ctrl_q <= {23'h00_0000, i_pwdata[8:0]};
            if (hit_m)
                minvel_q <= i_pwdata[VW-1:0];
            if (hit_k)
                cool_q <= i_pwdata[19:0];
            if (hit_q)
                quiet_q <= i_pwdata[19:0];
            if (hit_r)
                mres_q <= i_pwdata[3:0];
        end
    end

    // read mux; status shows the block's live state
    wire [31:0] stat_w = {28'h000_0000, o_chop_const_off, adaptive, o_step_ready_out, stall_q};
    wire [31:0] rd_w   = ({32{hit_c}} & ctrl_q)
                       | ({32{hit_m}} & 32'(minvel_q))
                       | ({32{hit_k}} & {12'h000, cool_q})
                       | ({32{hit_q}} & {12'h000, quiet_q})
                       | ({32{hit_r}} & {28'h000_0000, mres_q})
                       | ({32{hit_s}} & stat_w)
                       | ({32{hit_l}} & {12'h000, lost_q})
                       | ({32{hit_p}} & {22'h00_0000, pos_q});

    // pready is a flop set from the setup phase, so no wait state is added
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_pready  <= 1'b0;
            o_prdata  <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end
        else
        begin
            o_pready  <= setup;
            o_prdata  <= setup ? rd_w : 32'h0000_0000;
            o_pslverr <= setup & ~mapped;
        end
    end

    // ==========================================
    // checks
    a_sync_halt: assert property (@(posedge i_mclk) disable iff (i_rst)
        !sync_s |=> !o_step_ready_out && $stable(pos_q))
        else $error("sync low did not halt stepping");
    a_dir_up: assert property (@(posedge i_mclk) disable iff (i_rst)
        us_go && !dir_s |=> pos_q == 10'($past(pos_q) + $past(ust_w)))
        else $error("low direction did not move up");
    a_lost_count: assert property (@(posedge i_mclk) disable iff (i_rst)
        untaken && !dir_s && !(wr && hit_l) |=> lost_q == 20'($past(lost_q) + 1'b1))
        else $error("lost step not counted");
    a_skip_toggle: assert property (@(posedge i_mclk) disable iff (i_rst)
        untaken |=> skip_q != $past(skip_q))
        else $error("skip level did not toggle");
    a_long_force: assert property (@(posedge i_mclk) disable iff (i_rst)
        adaptive && sync_s && full && f_long |=> pos_q != $past(pos_q))
        else $error("long pulse did not force a step");
    a_quiet_block: assert property (@(posedge i_mclk) disable iff (i_rst)
        quiet |=> !o_adaptive_active)
        else $error("adaptive mode while quiet chopper active");
    a_const_off: assert property (@(posedge i_mclk) disable iff (i_rst)
        adaptive |=> o_chop_const_off)
        else $error("chopper not forced to constant off time");
    a_stall_pin: assert property (@(posedge i_mclk) disable iff (i_rst)
        pp1 && ctrl_q[`AFS_CTL_S1_LO +: 3] == 3'h0 |=> o_diag_out_one == $past(stall_s))
        else $error("stall diag wrong");
    a_fullstep: assert property (@(posedge i_mclk) disable iff (i_rst)
        exec |=> pos_q[7:0] == 8'h80)
        else $error("adaptive step not on a fullstep");
    a_min_vel: assert property (@(posedge i_mclk) disable iff (i_rst)
        minvel_q == '0 |-> !f_min)
        else $error("zero minimum velocity forced a step");

    // ==========================================
    // pins, buffer and counters
    // reset itself is the condition here, so this one has no disable
    a_rst_diag0: assert property (@(posedge i_mclk)
        $past(i_rst) && i_rst |-> !o_diag_out_zero && o_diag_out_zero_oe)
        else $error("diag zero not pulled low in reset");
    a_open_drain: assert property (@(posedge i_mclk) disable iff (i_rst)
        !pp0 |=> !o_diag_out_zero)
        else $error("open drain diag drove high");
    a_index_pin: assert property (@(posedge i_mclk) disable iff (i_rst)
        pp1 && ctrl_q[`AFS_CTL_S1_LO +: 3] == 3'h1 |=> o_diag_out_one == $past(index_s))
        else $error("index diag wrong");
    a_chop_alt: assert property (@(posedge i_mclk) disable iff (i_rst)
        chop_p_q && !chop_sel |=> alt_q != $past(alt_q))
        else $error("chopper diag did not change coil");
    a_adapt_on: assert property (@(posedge i_mclk) disable iff (i_rst)
        en_s && !quiet |=> o_adaptive_active)
        else $error("enable input did not force adaptive mode");
    a_ready_low: assert property (@(posedge i_mclk) disable iff (i_rst)
        !sync_s || (adaptive && !i_step_taken) |=> !o_step_ready_out)
        else $error("ready high while motor not ready");
    a_buf_take: assert property (@(posedge i_mclk) disable iff (i_rst)
        adaptive && step_rs && !full && !(wr && hit_l) |=> lost_q == $past(lost_q))
        else $error("step lost while buffer had room");
    a_lost_down: assert property (@(posedge i_mclk) disable iff (i_rst)
        untaken && dir_s && !(wr && hit_l) |=> lost_q == 20'($past(lost_q) - 1'b1))
        else $error("lost step not counted down");
    a_min_force: assert property (@(posedge i_mclk) disable iff (i_rst)
        adaptive && sync_s && full && f_min |=> pos_q != $past(pos_q))
        else $error("minimum velocity did not force a step");
    a_stall_set: assert property (@(posedge i_mclk) disable iff (i_rst)
        blocked |=> stall_q)
        else $error("blocked motor did not set stall flag");
    a_dir_down: assert property (@(posedge i_mclk) disable iff (i_rst)
        us_go && dir_s |=> pos_q == 10'($past(pos_q) - $past(ust_w)))
        else $error("high direction did not move down");
endmodule : afs_step_ctl
`default_nettype wire

// ### test/afs_mc_model.sv
// Purpose: behavioural motion controller issuing step and direction
// Assumes: commanded by the bench, clocked by i_mclk
// Notes:   long mode holds step high well past the override limit
`default_nettype none
module afs_mc_model (
    // clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_rst,
    // bench commands
    input  wire logic        i_go,
    input  wire logic        i_honor,
    input  wire logic        i_long,
    input  wire logic        i_dir_cmd,
    // driver pins
    input  wire logic        i_ready,
    output logic             o_step,
    output logic             o_dir,
    output logic      [15:0] o_sent
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [10:0] cnt_q;
    // ==========================================
    // pulse generator: each level held long enough to pass the input filters
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_step <= 1'b0;
            o_dir  <= 1'b0;
            o_sent <= 16'h0000;
            cnt_q  <= 11'h000;
        end
        else if (cnt_q != 11'h000)
            cnt_q <= cnt_q - 11'h001;
        else if (o_step)
        begin
            o_step <= 1'b0;
            cnt_q  <= 11'h003;
        end
        else
        begin
            o_dir <= i_dir_cmd;
            if (i_go && (!i_honor || i_ready))
            begin
                o_step <= 1'b1;
                cnt_q  <= i_long ? 11'h44C : 11'h003;
                o_sent <= o_sent + 16'h0001;
            end
        end
    end
endmodule : afs_mc_model
`default_nettype wire

// ### test/adaptive_fullstep_step_handshake_tb_top.sv
// Purpose: self-checking bench for the step handshake block
// Assumes: zero wait-state register bus, pins seen three edges late
// Notes:   expectations come from register, stepping, buffering and diag behaviour
`include "afs_defs.svh"
`default_nettype none
module adaptive_fullstep_step_handshake_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic        sync = 1'b1, en = 1'b0, taken = 1'b1, cha = 1'b0, chb = 1'b0;
    logic        go = 1'b0, honor = 1'b0, lng = 1'b0, dcmd = 1'b0, err;
    logic        step, dir, pready, perr, rdy, cof, act, d0, d0oe, d1, d1oe;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic [9:0]  load = 10'h155, p0, nz;
    logic [15:0] sent;
    int          n_mismatch = 0, num_checks = 0, cyc = 0, tog = 0;

    always #5 mclk = ~mclk;
    // skip diag edges are counted, not sampled, so none is missed
    always @(d1) tog = tog + 1;

    afs_step_ctl dut (.i_mclk(mclk), .i_rst(rst), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(perr), .i_step(step), .i_dir(dir),
        .i_step_sync_in(sync), .i_adaptive_mode_enable_in(en), .o_step_ready_out(rdy),
        .i_load_measure_result(load), .i_step_taken(taken), .i_chop_on_a(cha),
        .i_chop_on_b(chb), .o_chop_const_off(cof), .o_adaptive_active(act),
        .o_diag_out_zero(d0), .o_diag_out_zero_oe(d0oe), .o_diag_out_one(d1),
        .o_diag_out_one_oe(d1oe));
    afs_mc_model mc (.i_mclk(mclk), .i_rst(rst), .i_go(go), .i_honor(honor),
        .i_long(lng), .i_dir_cmd(dcmd), .i_ready(rdy), .o_step(step), .o_dir(dir),
        .o_sent(sent));

    // ==========================================
    // closing report and hang guard
    task automatic test_done();
        if (n_mismatch == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : test_done

    always @(posedge mclk)
    begin
        cyc = cyc + 1;
        if (cyc == 40000)
        begin
            n_mismatch = n_mismatch + 1;
            test_done();
        end
    end

    // ==========================================
    // access tasks
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        num_checks = num_checks + 1;
        if (got !== exp)
        begin
            $display("BAD %s expected %h seen %h", nm, exp, got);
            n_mismatch = n_mismatch + 1;
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask : tick

    // request held from setup until pready is seen high at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel   <= 1'b1;
        pen    <= 1'b0;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge mclk);
        pen <= 1'b1;
        do
        begin
            @(posedge mclk);
        end
        while (pready !== 1'b1);
        rd  = prdata;
        err = perr;
        psel <= 1'b0;
        pen  <= 1'b0;
        // idle edge so a following call never re-drives psel in this step
        @(posedge mclk);
    endtask : apb

    task automatic rdpos();
        apb(1'b0, `AFS_OFS_POS, 32'h0000_0000);
        p0 = rd[9:0];
    endtask : rdpos

    // go is dropped well before the model can start a further pulse
    task automatic run(input int n, input logic dr);
        logic [15:0] s0;
        dcmd <= dr;
        tick(2);
        if (n > 0)
        begin
            s0 = sent;
            go <= 1'b1;
            while (sent !== s0 + 16'(n)) @(posedge mclk);
            go <= 1'b0;
        end
        tick(2);
        while (step === 1'b1) @(posedge mclk);
        tick(12);
    endtask : run

    task automatic do_reset();
        rst <= 1'b1;
        tick(5);
        chk("diag0 in reset", {d0, d0oe}, 2'b01);
        chk("ready in reset", rdy, 1'b0);
        tick(5);
        rst <= 1'b0;
        tick(3);
    endtask : do_reset

    // ==========================================
    // main sequence
    initial
    begin
        do_reset();
        apb(1'b0, `AFS_OFS_CTRL, 32'h0000_0000);
        chk("ctrl reset", rd, 32'h0000_0020);
        apb(1'b0, 12'h020, 32'h0000_0000);
        chk("unmapped err", err, 1'b1);
        chk("unmapped data", rd, 32'h0000_0000);
        // stall: zero load inside, then outside, the velocity window
        apb(1'b1, `AFS_OFS_COOL, 32'h000F_FFFF);
        load <= 10'h000;
        tick(6);
        chk("stall active", {d0, d0oe}, 2'b01);
        apb(1'b1, `AFS_OFS_COOL, 32'h0000_0010);
        tick(6);
        chk("stall above window", d0oe, 1'b0);
        load <= 10'h155;
        // plain stepping moves one table entry per pulse
        rdpos();
        run(4, 1'b0);
        apb(1'b0, `AFS_OFS_POS, 32'h0000_0000);
        chk("pos up", rd[9:0], p0 + 10'd4);
        run(2, 1'b1);
        apb(1'b0, `AFS_OFS_POS, 32'h0000_0000);
        chk("pos down", rd[9:0], p0 + 10'd2);
        sync <= 1'b0;
        tick(5);
        chk("ready sync low", rdy, 1'b0);
        run(2, 1'b0);
        apb(1'b0, `AFS_OFS_POS, 32'h0000_0000);
        chk("pos halted", rd[9:0], p0 + 10'd2);
        sync <= 1'b1;
        tick(5);
        chk("ready again", rdy, 1'b1);
        // adaptive entry is held off while the quiet chopper runs
        apb(1'b1, `AFS_OFS_QUIET, 32'h0000_0010);
        en <= 1'b1;
        tick(5);
        chk("quiet inhibits", act, 1'b0);
        apb(1'b1, `AFS_OFS_QUIET, 32'h0000_0000);
        tick(5);
        chk("adaptive forced", {act, cof}, 2'b11);
        // overload: two microsteps buffered, the rest lost, in each direction
        for (int i = 0; i < 2; i++)
        begin
            do_reset();
            apb(1'b1, `AFS_OFS_MRES, 32'h0000_0001);
            apb(1'b1, `AFS_OFS_CTRL, 32'h0000_0170);
            taken <= 1'b0;
            tick(5);
            chk("ready overload", rdy, 1'b0);
            tog = 0;
            run(5, i[0]);
            chk("skip toggles", tog, 3);
            apb(1'b0, `AFS_OFS_LOST, 32'h0000_0000);
            chk("lost steps", rd[19:0], i ? 20'hF_FFFD : 20'h0_0003);
        end
        // a controller that honours ready sends nothing while it is low
        honor <= 1'b1;
        go    <= 1'b1;
        tick(40);
        go    <= 1'b0;
        honor <= 1'b0;
        apb(1'b0, `AFS_OFS_LOST, 32'h0000_0000);
        chk("lost held", rd[19:0], 20'hF_FFFD);
        // a long pulse overrides the blocked wait with a whole fullstep
        rdpos();
        lng <= 1'b1;
        run(1, 1'b1);
        lng <= 1'b0;
        apb(1'b0, `AFS_OFS_POS, 32'h0000_0000);
        chk("forced fullstep", rd[7:0], 8'h80);
        chk("forced moved", rd[9:0] !== p0, 1'b1);
        // minimum velocity: idle at zero, then stepping a blocked motor
        run(2, 1'b0);
        rdpos();
        tick(300);
        apb(1'b0, `AFS_OFS_POS, 32'h0000_0000);
        chk("minvel off", rd[9:0], p0);
        apb(1'b1, `AFS_OFS_MINVEL, 32'h0000_0064);
        tick(300);
        apb(1'b0, `AFS_OFS_POS, 32'h0000_0000);
        chk("minvel step", rd[9:0] !== p0, 1'b1);
        apb(1'b0, `AFS_OFS_STAT, 32'h0000_0000);
        chk("stall flag", rd[0], 1'b1);
        // index: walk the position to zero at full resolution
        en <= 1'b0;
        taken <= 1'b1;
        apb(1'b1, `AFS_OFS_MRES, 32'h0000_0008);
        apb(1'b1, `AFS_OFS_CTRL, 32'h0000_0120);
        rdpos();
        nz = 10'h000 - p0;
        run(int'(nz), 1'b0);
        chk("index on", d1, 1'b1);
        run(1, 1'b0);
        chk("index off", d1, 1'b0);
        // chopper on-state hands over to the other coil as each phase ends
        apb(1'b1, `AFS_OFS_CTRL, 32'h0000_0014);
        cha <= 1'b1;
        tick(6);
        chk("coil a on", d0, 1'b1);
        cha <= 1'b0;
        chb <= 1'b1;
        tick(6);
        chk("coil b on", d0, 1'b1);
        test_done();
    end
endmodule : adaptive_fullstep_step_handshake_tb_top
`default_nettype wire
